/* src/ouhp_host_port.sv */
// host bus port of the octal uart: decode, strobes, interrupt line, modem pins
`timescale 1ns/100ps
module ouhp_host_port
    import ouhp_pkg::*;
#(
    parameter int NCH = NUM_CHAN
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic busStyle,
    input wire logic [7:0] addr,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic chipSelN,
    output logic irqOut,
    output logic irqOe,
    input wire logic [NCH-1:0] chanIrq,
    input wire logic [NCH-1:0] serialIn,
    output logic [NCH-1:0] serialInDec,
    output logic [NCH-1:0] requestSendN,
    output logic [NCH-1:0] terminalReadyN,
    input wire logic [NCH-1:0] clearSendN,
    input wire logic [NCH-1:0] setReadyN,
    input wire logic [NCH-1:0] carrierDetectN,
    input wire logic [NCH-1:0] ringIndicatorN,
    input wire logic [NCH-1:0] flowReady,
    input wire logic [NCH-1:0] txActive,
    output logic [NCH-1:0] txPermit,
    output logic [NCH*FC_HYST_BITS-1:0] flowHysteresis
);
    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rstSync_q;
    logic rstnS;
    localparam int PW = 8 + 8 + 4 + 5 * NCH;
    logic [PW-1:0] pinMeta_q;
    logic [PW-1:0] pinSync_q;
    logic [7:0] addrS;
    logic [7:0] dataS;
    logic styleS;
    logic rdNS;
    logic wrNS;
    logic csNS;
    logic [NCH-1:0] rxS;
    logic [NCH-1:0] ctsS;
    logic [NCH-1:0] dsrS;
    logic [NCH-1:0] cdS;
    logic [NCH-1:0] riS;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync_q <= 2'b00;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstnS = rstSync_q[1];

    // idle levels loaded at reset so no false strobe edge appears on release
    always_ff @(posedge core_clk or negedge rstnS) begin
        if (!rstnS) begin
            pinMeta_q <= {{(PW-19){1'b1}}, 3'b111, 16'h0000};
            pinSync_q <= {{(PW-19){1'b1}}, 3'b111, 16'h0000};
        end else begin
            pinMeta_q <= {serialIn, ringIndicatorN, carrierDetectN, setReadyN, clearSendN,
                          busStyle, readStrobeN, writeStrobeN, chipSelN, dataIn, addr};
            pinSync_q <= pinMeta_q;
        end
    end
    assign {rxS, riS, cdS, dsrS, ctsS, styleS, rdNS, wrNS, csNS, dataS, addrS} = pinSync_q;

    // ----------------------------------------------------------------
    // strobe decode
    // ----------------------------------------------------------------
    logic rdAct;
    logic wrAct;
    logic rdAct_q;
    logic wrAct_q;
    logic rdStart;
    logic wrEnd;

    // separate strobes gated by chip select, or chip select as strobe with direction line
    assign rdAct = styleS ? (!csNS && !rdNS) // R2 R4
                          : (!csNS && wrNS); // R5 R6 R7
    assign wrAct = styleS ? (!csNS && !wrNS) // R3 R4
                          : (!csNS && !wrNS); // R5 R6
    assign rdStart = rdAct && !rdAct_q; // R2
    assign wrEnd = !wrAct && wrAct_q; // R3

    always_ff @(posedge core_clk or negedge rstnS) begin
        if (!rstnS) begin
            rdAct_q <= 1'b0;
            wrAct_q <= 1'b0;
        end else begin
            rdAct_q <= rdAct;
            wrAct_q <= wrAct;
        end
    end

    // write address and data follow the bus while the strobe is low, last value wins
    logic [7:0] wrAddr_q;
    logic [7:0] wrData_q;
    always_ff @(posedge core_clk or negedge rstnS) begin
        if (!rstnS) begin
            wrAddr_q <= 8'h00;
            wrData_q <= 8'h00;
        end else if (wrAct) begin
            wrAddr_q <= addrS;
            wrData_q <= dataS;
        end
    end

    logic wrGlobal;
    logic [CHAN_BITS-1:0] wrChan;
    logic [REG_BITS-1:0] wrReg;
    assign wrGlobal = wrAddr_q[GLOBAL_BIT]; // R1
    assign wrChan = wrAddr_q[CHAN_LSB +: CHAN_BITS]; // R1
    assign wrReg = wrAddr_q[REG_LSB +: REG_BITS]; // R1

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    ouhp_mem_if #(.AW(MEM_AW), .DW(8)) memBus ();

    assign memBus.wrEn = wrEnd && !wrGlobal; // R3
    assign memBus.wrAddr = wrAddr_q[MEM_AW-1:0];
    assign memBus.wrData = wrData_q;
    assign memBus.rdEn = rdStart;
    assign memBus.rdAddr = addrS[MEM_AW-1:0];

    ouhp_reg_mem #(.AW(MEM_AW), .DW(8)) regMem (
        .clk(core_clk),
        .port(memBus)
    );

    // ----------------------------------------------------------------
    // per-channel control shadows and modem pin functions
    // ----------------------------------------------------------------
    logic [7:0] feature_control_reg_q [NCH];
    logic [7:0] efr_q [NCH];
    logic [7:0] mcr_q [NCH];
    logic [7:0] modemStat [NCH];
    logic [NCH-1:0] rxDec_q;
    logic [NCH-1:0] rtsN_q;
    logic [NCH-1:0] dtrN_q;
    logic [NCH-1:0] txPermit_q;
    logic [NCH*FC_HYST_BITS-1:0] hyst_q;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : gChan
            logic hit;
            logic flowOnDtr;
            assign hit = wrEnd && !wrGlobal && (wrChan == CHAN_BITS'(ch)); // R1
            assign flowOnDtr = mcr_q[ch][MC_DTR_FLOW];

            // shadow copies steer the pin logic without a memory read per channel
            always_ff @(posedge core_clk or negedge rstnS) begin
                if (!rstnS) begin
                    feature_control_reg_q[ch] <= REG_RESET;
                    efr_q[ch] <= REG_RESET;
                    mcr_q[ch] <= REG_RESET;
                end else if (hit) begin
                    if (wrReg == OFS_FEATURE_CONTROL) begin
                        feature_control_reg_q[ch] <= wrData_q; // R3
                    end
                    if (wrReg == OFS_ENHANCED_FEATURE) begin
                        efr_q[ch] <= wrData_q; // R3
                    end
                    if (wrReg == OFS_MODEM_CONTROL) begin
                        mcr_q[ch] <= wrData_q; // R3
                    end
                end
            end

            // modem status shows the inputs as true levels, low pin reads as one
            assign modemStat[ch] = {!cdS[ch], !riS[ch], !dsrS[ch], !ctsS[ch], 4'h0}; // R16

            always_ff @(posedge core_clk or negedge rstnS) begin
                if (!rstnS) begin
                    rxDec_q[ch] <= 1'b1;
                    rtsN_q[ch] <= 1'b1;
                    dtrN_q[ch] <= 1'b1;
                    txPermit_q[ch] <= 1'b1;
                    hyst_q[ch*FC_HYST_BITS +: FC_HYST_BITS] <= 4'h0;
                end else begin
                    // normal receive passes through idle high, ir pulse optionally inverted
                    rxDec_q[ch] <= rxS[ch] ^ feature_control_reg_q[ch][FC_IR_INVERT]; // R10 R11
                    if (feature_control_reg_q[ch][FC_RS485]) begin
                        rtsN_q[ch] <= !txActive[ch]; // R12 R15
                    end else if (efr_q[ch][EF_AUTO_RTS] && !flowOnDtr) begin
                        rtsN_q[ch] <= !flowReady[ch]; // R12 R15
                    end else begin
                        rtsN_q[ch] <= !mcr_q[ch][MC_RTS]; // R15
                    end
                    if (efr_q[ch][EF_AUTO_RTS] && flowOnDtr) begin
                        dtrN_q[ch] <= !flowReady[ch]; // R13 R15
                    end else begin
                        dtrN_q[ch] <= !mcr_q[ch][MC_DTR]; // R15
                    end
                    // transmit waits for the partner's active-low ready when enabled
                    txPermit_q[ch] <= !efr_q[ch][EF_AUTO_CTS] ||
                                      (flowOnDtr ? !dsrS[ch] : !ctsS[ch]); // R14
                    hyst_q[ch*FC_HYST_BITS +: FC_HYST_BITS] <=
                        feature_control_reg_q[ch][FC_HYST_LSB +: FC_HYST_BITS]; // R13
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // read path and data bus drive
    // ----------------------------------------------------------------
    ouhp_src_type src_q;
    logic [CHAN_BITS-1:0] rdChan_q;
    logic rdPend_q;
    logic [7:0] dataOut_q;
    logic dataOe_q;

    // the source is chosen at the strobe edge so a moving address cannot tear the byte
    always_ff @(posedge core_clk or negedge rstnS) begin
        if (!rstnS) begin
            src_q <= SRC_ZERO;
            rdChan_q <= '0;
            rdPend_q <= 1'b0;
        end else begin
            rdPend_q <= rdStart;
            if (rdStart) begin
                rdChan_q <= addrS[CHAN_LSB +: CHAN_BITS]; // R1
                if (addrS[GLOBAL_BIT]) begin
                    src_q <= (addrS[GLOBAL_BIT-1:0] == OFS_IRQ_SOURCE) ? // R1 R9
                             SRC_IRQ : SRC_ZERO;
                end else if (addrS[REG_LSB +: REG_BITS] == OFS_MODEM_STATUS) begin
                    src_q <= SRC_MODEM;
                end else begin
                    src_q <= SRC_MEM;
                end
            end
        end
    end

    // enable rises with the byte, two cycles after the detected edge, and drops with the strobe
    always_ff @(posedge core_clk or negedge rstnS) begin
        if (!rstnS) begin
            dataOut_q <= 8'h00;
            dataOe_q <= 1'b0;
        end else begin
            if (rdPend_q) begin
                case (src_q)
                    SRC_MEM: dataOut_q <= memBus.rdData; // R2
                    SRC_MODEM: dataOut_q <= modemStat[rdChan_q]; // R16
                    SRC_IRQ: dataOut_q <= 8'(chanIrq); // R9
                    default: dataOut_q <= 8'h00;
                endcase
            end
            dataOe_q <= rdAct && (dataOe_q || rdPend_q); // R2 R17
        end
    end

    // ----------------------------------------------------------------
    // shared interrupt line
    // ----------------------------------------------------------------
    logic irqOe_q;
    logic irqOut_q;
    always_ff @(posedge core_clk or negedge rstnS) begin
        if (!rstnS) begin
            irqOe_q <= 1'b0;
            irqOut_q <= 1'b0;
        end else begin
            irqOe_q <= |chanIrq; // R8
            irqOut_q <= 1'b0; // R8
        end
    end

    assign dataOut = dataOut_q;
    assign dataOe = dataOe_q;
    assign irqOut = irqOut_q;
    assign irqOe = irqOe_q;
    assign serialInDec = rxDec_q;
    assign requestSendN = rtsN_q;
    assign terminalReadyN = dtrN_q;
    assign txPermit = txPermit_q;
    assign flowHysteresis = hyst_q;
endmodule

/* src/ouhp_pkg.sv */
// constants and types shared by the octal uart host bus port
//
// Behaviour
// R1 - address low nibble picks register, next three bits channel, top bit global space
// R2 - strap high: read strobe falling edge starts read, byte driven onto data bus
// R3 - strap high: write strobe falling starts write, byte stored on rising edge
// R4 - strap high: strobes only honoured while chip select is low
// R5 - strap low: write strobe pin is direction, high read, low write
// R6 - strap low: chip select is the single active-low strobe for both accesses
// R7 - combined-strobe style: system ties read strobe high, never toggles it
// R8 - all channel interrupts on one active-low open-drain shareable output
// R9 - global interrupt source register shows pending status of all eight channels
// R10 - receive input idles high in normal non-infrared operation
// R11 - feature control bit 4 inverts incoming infrared pulse before decoding
// R12 - request-to-send does auto flow or rs485 direction, chosen by feature bit 5
// R13 - terminal-ready does auto flow via enhanced bit 6, hysteresis feature bits 0-3
// R14 - clear-to-send and set-ready give auto transmit flow via enhanced bit 7
// R15 - request-to-send and terminal-ready active low, else general purpose outputs
// R16 - carrier-detect and ring-indicator active low, readable as general inputs
// R17 - data bus released whenever no read access is in progress
package ouhp_pkg;
    // ----------------------------------------------------------------
    // address layout
    // ----------------------------------------------------------------
    localparam int REG_LSB = 0;
    localparam int REG_BITS = 4;
    localparam int CHAN_LSB = 4;
    localparam int CHAN_BITS = 3;
    localparam int GLOBAL_BIT = 7;
    localparam int NUM_CHAN = 8;
    localparam int MEM_AW = 7;

    // ----------------------------------------------------------------
    // per-channel register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_MODEM_CONTROL = 4'h4;
    localparam logic [3:0] OFS_MODEM_STATUS = 4'h6;
    localparam logic [3:0] OFS_FEATURE_CONTROL = 4'h8;
    localparam logic [3:0] OFS_ENHANCED_FEATURE = 4'h9;
    // global space offsets
    localparam logic [6:0] OFS_IRQ_SOURCE = 7'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int FC_HYST_LSB = 0;
    localparam int FC_HYST_BITS = 4;
    localparam int FC_IR_INVERT = 4;
    localparam int FC_RS485 = 5;
    localparam int EF_AUTO_RTS = 6;
    localparam int EF_AUTO_CTS = 7;
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_DTR_FLOW = 2;
    localparam int MS_CTS = 4;
    localparam int MS_DSR = 5;
    localparam int MS_RI = 6;
    localparam int MS_CD = 7;

    localparam logic [7:0] REG_RESET = 8'h00;

    // source of the byte returned by a read
    typedef enum logic [1:0] {
        SRC_MEM = 2'b00,
        SRC_MODEM = 2'b01,
        SRC_IRQ = 2'b10,
        SRC_ZERO = 2'b11
    } ouhp_src_type;
endpackage

/* src/ouhp_mem_if.sv */
// register memory access bundle between port control and storage
`timescale 1ns/100ps
interface ouhp_mem_if #(parameter int AW = 7, parameter int DW = 8);
    logic wrEn;
    logic [AW-1:0] wrAddr;
    logic [DW-1:0] wrData;
    logic rdEn;
    logic [AW-1:0] rdAddr;
    logic [DW-1:0] rdData;
    modport ctrl (output wrEn, output wrAddr, output wrData, output rdEn, output rdAddr,
                  input rdData);
    modport mem (input wrEn, input wrAddr, input wrData, input rdEn, input rdAddr,
                 output rdData);
endinterface

/* src/ouhp_reg_mem.sv */
// per-channel register storage with registered read data
`timescale 1ns/100ps
module ouhp_reg_mem
    import ouhp_pkg::*;
#(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic clk,
    ouhp_mem_if.mem port
);
    logic [DW-1:0] store [0:(1<<AW)-1];
    logic [DW-1:0] rdData_q;

    // no reset on the array so it maps to plain ram
    always_ff @(posedge clk) begin
        if (port.wrEn) begin
            store[port.wrAddr] <= port.wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (port.rdEn) begin
            rdData_q <= store[port.rdAddr];
        end
    end

    assign port.rdData = rdData_q;
endmodule

/* verif/ouhp_host_model.sv */
// host processor model driving the parallel bus in both strobe styles
`timescale 1ns/100ps
module ouhp_host_model (
    input wire logic clk,
    input wire logic style,
    output logic [7:0] addr,
    output logic [7:0] busData,
    output logic readStrobeN,
    output logic writeStrobeN,
    output logic chipSelN,
    input wire logic [7:0] dataOut,
    input wire logic dataOe
);
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    initial begin
        addr = 8'h00;
        busData = 8'h00;
        readStrobeN = 1'b1;
        writeStrobeN = 1'b1;
        chipSelN = 1'b1;
    end

    // strobe held six cycles so the two-stage pin sync surely sees it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        busData = d;
        writeStrobeN = 1'b0;
        chipSelN = 1'b0;
        repeat (6) @(negedge clk);
        writeStrobeN = 1'b1;
        chipSelN = 1'b1;
        busData = ~d; // released bus must not show the old byte
        repeat (6) @(negedge clk);
    endtask

    // holds the strobe until the device drives the bus, bounded wait
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        n = 0;
        addr = a;
        writeStrobeN = 1'b1;
        chipSelN = 1'b0;
        readStrobeN = !style;
        while (dataOe !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        d = (dataOe === 1'b1) ? dataOut : 8'hxx;
        chipSelN = 1'b1;
        readStrobeN = 1'b1;
        repeat (6) @(negedge clk);
    endtask
endmodule

/* verif/ouhp_host_port_chk.sv */
// assertion checker for the host bus port outputs
`timescale 1ns/100ps
module ouhp_host_port_chk #(
    parameter int NCH = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic busStyle,
    input wire logic chipSelN,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic dataOe,
    input wire logic [7:0] dataOut,
    input wire logic irqOut,
    input wire logic irqOe,
    input wire logic [NCH-1:0] chanIrq,
    input wire logic [NCH-1:0] serialInDec,
    input wire logic [NCH-1:0] requestSendN,
    input wire logic [NCH-1:0] terminalReadyN,
    input wire logic [NCH-1:0] txPermit
);
    // ----------------------------------------------------------------
    // bus and pin relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // two sync stages delay the answer, so it lands three to six edges late
    sequence s_answer;
        !dataOe [*3] ##[1:4] dataOe;
    endsequence
    sequence s_rdStart1;
        busStyle && !chipSelN && $fell(readStrobeN);
    endsequence
    sequence s_rdStart0;
        !busStyle && writeStrobeN && $fell(chipSelN);
    endsequence
    property p_rdAnswer1;
        s_rdStart1 |-> s_answer;
    endproperty
    property p_rdAnswer0;
        s_rdStart0 |-> s_answer;
    endproperty
    property p_csIdle;
        chipSelN [*5] |-> !dataOe;
    endproperty
    property p_rdIdle;
        (busStyle && readStrobeN) [*5] |-> !dataOe;
    endproperty
    property p_wrNoDrive;
        (!busStyle && !writeStrobeN) [*5] |-> !dataOe;
    endproperty
    property p_dataHold;
        dataOe && $past(dataOe) |-> $stable(dataOut);
    endproperty
    property p_irqDrive;
        irqOe == $past(|chanIrq);
    endproperty
    property p_irqLevel;
        irqOut == 1'b0;
    endproperty
    // internal reset copy still holds for two edges after the pin rises
    property p_rstValues;
        $rose(rstn) |-> (&requestSendN) && (&terminalReadyN) && (&txPermit) && !dataOe;
    endproperty
    a_rdAnswer1: assert property (p_rdAnswer1) else $error("style 1 read late");
    a_rdAnswer0: assert property (p_rdAnswer0) else $error("style 0 read late");
    a_csIdle: assert property (p_csIdle) else $error("bus driven unselected");
    a_rdIdle: assert property (p_rdIdle) else $error("bus driven without read");
    a_wrNoDrive: assert property (p_wrNoDrive) else $error("bus driven in write");
    a_dataHold: assert property (p_dataHold) else $error("read byte moved");
    a_irqDrive: assert property (p_irqDrive) else $error("irq enable wrong");
    a_irqLevel: assert property (p_irqLevel) else $error("irq drives high");
    a_rstValues: assert property (p_rstValues) else $error("reset values wrong");
endmodule

bind ouhp_host_port ouhp_host_port_chk #(.NCH(NCH)) chk (.core_clk, .rstn, .busStyle,
    .chipSelN, .readStrobeN, .writeStrobeN, .dataOe, .dataOut, .irqOut, .irqOe, .chanIrq,
    .serialInDec, .requestSendN, .terminalReadyN, .txPermit);

/* verif/ouhp_host_port_bench.sv */
// self-checking bench for the octal uart host bus port
`timescale 1ns/100ps
module ouhp_host_port_bench
    import ouhp_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic busStyle = 1'b1;
    logic [7:0] addr, busData, dataOut, rdData;
    logic readStrobeN, writeStrobeN, chipSelN, dataOe, irqOut, irqOe;
    logic [7:0] chanIrq = 8'h00, serialIn = 8'hff, clearSendN = 8'hfd, setReadyN = 8'hff;
    logic [7:0] carrierDetectN = 8'hfd, ringIndicatorN = 8'hff, flowReady = 8'h00;
    logic [7:0] txActive = 8'h00, serialInDec, requestSendN, terminalReadyN, txPermit;
    logic [31:0] flowHysteresis;
    int err_total = 0;
    int n_compared = 0;
    // style, address, write byte, expected read byte
    logic [24:0] rows [6] = '{{1'b1, 8'h03, 8'ha5, 8'ha5}, {1'b0, 8'h7f, 8'h5a, 8'h5a},
        {1'b1, 8'h25, 8'hc3, 8'hc3}, {1'b0, 8'h85, 8'hff, 8'h00},
        {1'b1, 8'h16, 8'hff, 8'h90}, {1'b0, 8'h03, 8'h3c, 8'h3c}};

    always #2.5 core_clk = ~core_clk;

    ouhp_host_port dut (.core_clk, .rstn, .busStyle, .addr, .dataIn(dataOe ? dataOut : busData),
        .dataOut, .dataOe, .readStrobeN, .writeStrobeN, .chipSelN, .irqOut, .irqOe, .chanIrq,
        .serialIn, .serialInDec, .requestSendN, .terminalReadyN, .clearSendN, .setReadyN,
        .carrierDetectN, .ringIndicatorN, .flowReady, .txActive, .txPermit, .flowHysteresis);
    ouhp_host_model m (.clk(core_clk), .style(busStyle), .addr, .busData, .readStrobeN,
        .writeStrobeN, .chipSelN, .dataOut, .dataOe);

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic settle;
        repeat (4) @(negedge core_clk);
    endtask

    // whole run is about three hundred cycles, so this only trips on a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("rts idle", 8'hff, requestSendN);
        chk("rx idle", 8'hff, serialInDec);
        foreach (rows[i]) begin
            busStyle = rows[i][24];
            repeat (3) @(negedge core_clk);
            m.wr(rows[i][23:16], rows[i][15:8]);
            m.rd(rows[i][23:16], rdData);
            chk("row read", rows[i][7:0], rdData);
        end
        // shared interrupt line and global source byte
        busStyle = 1'b1;
        chanIrq = 8'h24;
        settle();
        chk("irq drive", 8'h01, {7'h0, irqOe});
        m.rd(8'h80, rdData);
        chk("irq source", 8'h24, rdData);
        chanIrq = 8'h00;
        settle();
        chk("irq release", 8'h00, {7'h0, irqOe});
        // both strobes low while unselected must neither drive nor store
        m.addr = 8'h03;
        m.busData = 8'hee;
        m.readStrobeN = 1'b0;
        m.writeStrobeN = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("bus idle", 8'h00, {7'h0, dataOe});
        m.readStrobeN = 1'b1;
        m.writeStrobeN = 1'b1;
        m.rd(8'h03, rdData);
        chk("cs gate", 8'h3c, rdData);
        // modem pin functions of channel zero
        m.wr({4'h0, OFS_FEATURE_CONTROL}, 8'h1a);
        chk("ir invert", 8'hfe, serialInDec);
        chk("hysteresis", 8'h0a, {4'h0, flowHysteresis[3:0]});
        m.wr({4'h0, OFS_MODEM_CONTROL}, 8'h02);
        chk("rts gpo", 8'hfe, requestSendN);
        chk("dtr gpo", 8'hff, terminalReadyN);
        m.wr({4'h0, OFS_ENHANCED_FEATURE}, 8'hc0);
        chk("auto rts", 8'hff, requestSendN);
        chk("auto cts", 8'hfe, txPermit);
        clearSendN = 8'hfc;
        flowReady = 8'h01;
        settle();
        chk("rts ready", 8'hfe, requestSendN);
        chk("cts ready", 8'hff, txPermit);
        m.wr({4'h0, OFS_MODEM_CONTROL}, 8'h05);
        chk("auto dtr", 8'hfe, terminalReadyN);
        chk("auto dsr", 8'hfe, txPermit);
        m.wr({4'h0, OFS_FEATURE_CONTROL}, 8'h20);
        txActive = 8'h01;
        settle();
        chk("rs485 dir", 8'hfe, requestSendN);
        chk("rx plain", 8'hff, serialInDec);
        // second reset in mid-run clears the shadows
        rstn = 1'b0;
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("reset rts", 8'hff, requestSendN);
        chk("reset dtr", 8'hff, terminalReadyN);
        stop_test();
    end
endmodule
